// ---- sfcd_sync.sv ----
// ============================================================
// package: shared constants and types
package sfcd_pkg;
	localparam logic [7:0] OPC_WREN = 8'h06;
	localparam logic [7:0] OPC_WRDI = 8'h04;
	localparam logic [7:0] OPC_RDSR = 8'h05;
	localparam logic [7:0] OPC_WRSR = 8'h01;
	localparam logic [7:0] OPC_READ = 8'h03;
	localparam logic [7:0] OPC_PROG = 8'h02;
	localparam logic [7:0] OPC_SERASE = 8'hD8;
	localparam logic [7:0] OPC_CERASE = 8'hC7;
	localparam logic [7:0] OPC_PDOWN = 8'hB9;
	localparam logic [7:0] OPC_RELEASE = 8'hAB;
	// status bit positions
	localparam int STAT_BUSY_POS = 0;
	localparam int STAT_WEL_POS = 1;
	localparam int STAT_BP_LSB = 2;
	localparam int STAT_BP_MSB = 4;
	localparam int STAT_LOCK_POS = 7;
	// reset values
	localparam logic STAT_WEL_RST = 1'b0;
	localparam logic STAT_LOCK_RST = 1'b0;
	localparam logic [2:0] STAT_BP_RST = 3'h0;
	// identification byte: value is arbitrary
	localparam logic [7:0] SFCD_ID_BYTE = 8'h5A;
	// index of the last address or dummy byte after the opcode
	localparam logic [1:0] ADDR_LAST_IDX = 2'h2;
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int STATUS_WRITE_TIME_NS_DEF = 10000000;
	localparam int WTIMER_W = 24;
	typedef enum logic [2:0] {
		ST_CMD = 3'b000,
		ST_ADDR = 3'b001,
		ST_DUMMY = 3'b010,
		ST_OUT = 3'b011,
		ST_WDATA = 3'b100,
		ST_END = 3'b101,
		ST_IGN = 3'b110
	} sfcd_state_e;
	typedef enum logic [1:0] {
		SRC_STAT = 2'b00,
		SRC_ARR = 2'b01,
		SRC_ID = 2'b10
	} sfcd_src_e;
endpackage : sfcd_pkg

// ============================================================
// two-flop synchroniser for pin inputs
module sfcd_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : sfcd_sync

// ---- sfcd_decoder.sv ----
// ============================================================
// serial flash instruction decoder
// Overview of operation
// - Opcode 06h then select rising sets the write latch flag.
// - Opcode 04h then select rising clears the write latch flag.
// - Program, erase and status write are refused unless the latch flag is set.
// - Latch flag clears at reset and when a write-type cycle completes.
// - After 05h, status bits go out on falling edges, MSB first.
// - Status byte repeats while select stays low and clocks run.
// - Status read is accepted at any time except in power-down, even while busy.
// - Status write changes only lock and protect level bits.
// - Status write not ending on a byte boundary is discarded.
// - Valid status write runs a timed cycle with busy set, then clears busy and latch.
// - With lock set, status writes are rejected while guard pin is low.
// - Array read streams bytes on falling edges, address incremented per byte.
// - Array read while busy is ignored entirely.
// - Programming uses even start addresses, at least two data bytes per instruction.
// - ABh repeats the identification byte until select rises.
// - All bytes MSB first; returned bytes only on serial output.
// - Protect level bits sit at status bits 4..2, readable and writable.
// - Status bits 6 and 5 always read zero.
// - While busy, every instruction except status read is ignored.
module sfcd_decoder
	import sfcd_pkg::*;
#(
	parameter int STATUS_WRITE_TIME_NS = STATUS_WRITE_TIME_NS_DEF
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CS_N,
	input wire logic SCK,
	input wire logic SI,
	input wire logic WP_N,
	output logic SO,
	output logic SO_OE,
	output logic [23:0] MEM_ADDR,
	output logic MEM_RD,
	input wire logic [7:0] MEM_RDATA,
	output logic ARRAY_GO,
	output logic [7:0] ARRAY_CMD,
	input wire logic ARRAY_DONE,
	output logic PROG_WE,
	output logic [7:0] PROG_DATA
);
	localparam int WS_CYC_RAW = (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WS_CYC = (WS_CYC_RAW < 1) ? 1 : WS_CYC_RAW;
	localparam logic [WTIMER_W-1:0] WS_LOAD = WTIMER_W'(WS_CYC - 1);

	typedef struct packed {
		sfcd_state_e state;
		sfcd_src_e src;
		logic sck_d;
		logic cs_d;
		logic [7:0] opc;
		logic [7:0] sh;
		logic [2:0] bcnt;
		logic [1:0] nb;
		logic [1:0] dcnt;
		logic [23:0] addr;
		logic [7:0] rbuf;
		logic rd_wait;
		logic [7:0] osh;
		logic [2:0] ocnt;
		logic so;
		logic so_oe;
		logic write_latch_flag;
		logic lock;
		logic [2:0] bp;
		logic pdn;
		logic busy_ws;
		logic busy_arr;
		logic [WTIMER_W-1:0] wtimer;
		logic [7:0] wdata;
		logic mem_rd;
		logic arr_go;
		logic [7:0] arr_cmd;
		logic prog_we;
		logic [7:0] prog_data;
	} sfcd_regs_s;

	sfcd_regs_s r;
	sfcd_regs_s n;
	logic cs_s;
	logic sck_s;
	logic si_s;
	logic wp_s;
	logic rise;
	logic fall;
	logic cs_up;
	logic busy;
	logic [7:0] stat;
	logic [7:0] byte_in;

	function automatic logic [7:0] stat_byte(input logic lock, input logic [2:0] bp,
			input logic write_latch_flag, input logic bsy);
		logic [7:0] s;
		s = 8'h00;
		s[STAT_LOCK_POS] = lock;
		s[STAT_BP_MSB:STAT_BP_LSB] = bp;
		s[STAT_WEL_POS] = write_latch_flag;
		s[STAT_BUSY_POS] = bsy;
		return s;
	endfunction : stat_byte

	// ============================================================
	// pin synchronisers
	sfcd_sync #(.W(4), .RST_VAL(4'hB)) u_sync (
		.clk(CLK),
		.resetn(RESETN),
		.d({CS_N, SCK, SI, WP_N}),
		.q({cs_s, sck_s, si_s, wp_s})
	);

	// ============================================================
	// edge detection and status view
	assign rise = !cs_s && sck_s && !r.sck_d;
	assign fall = !cs_s && !sck_s && r.sck_d;
	assign cs_up = cs_s && !r.cs_d;
	assign busy = r.busy_ws || r.busy_arr;
	assign byte_in = {r.sh[6:0], si_s};
	assign stat = stat_byte(r.lock, r.bp, r.write_latch_flag, busy);

	// ============================================================
	// next state
	always_comb begin
		logic [7:0] ob;
		ob = 8'h00;
		n = r;
		n.mem_rd = 1'b0;
		n.arr_go = 1'b0;
		n.prog_we = 1'b0;
		n.sck_d = sck_s;
		n.cs_d = cs_s;
		n.rd_wait = r.mem_rd;
		// self-timed status write
		if (r.busy_ws) begin
			if (r.wtimer == '0) begin
				n.busy_ws = 1'b0;
				n.write_latch_flag = 1'b0;
				n.lock = r.wdata[STAT_LOCK_POS];
				n.bp = r.wdata[STAT_BP_MSB:STAT_BP_LSB];
			end else begin
				n.wtimer = r.wtimer - 1'b1;
			end
		end
		if (r.busy_arr && ARRAY_DONE) begin
			n.busy_arr = 1'b0;
			n.write_latch_flag = 1'b0;
		end
		// array read data returns the cycle after the request
		if (r.rd_wait) begin
			n.rbuf = MEM_RDATA;
			n.addr = r.addr + 24'h000001;
		end
		if (cs_up) begin
			case (r.state)
				ST_END: begin
					if (r.bcnt == 3'h0) begin
						case (r.opc)
							OPC_WREN: n.write_latch_flag = 1'b1;
							OPC_WRDI: n.write_latch_flag = 1'b0;
							OPC_PDOWN: n.pdn = 1'b1;
							OPC_SERASE, OPC_CERASE: begin
								if (r.write_latch_flag) begin
									n.arr_go = 1'b1;
									n.arr_cmd = r.opc;
									n.busy_arr = 1'b1;
								end
							end
							default: n.pdn = r.pdn;
						endcase
					end
				end
				ST_WDATA: begin
					if (r.bcnt == 3'h0 && r.write_latch_flag) begin
						if (r.opc == OPC_WRSR) begin
							if (r.dcnt == 2'h1 && !(r.lock && !wp_s)) begin
								n.busy_ws = 1'b1;
								n.wtimer = WS_LOAD;
							end
						end else if (r.dcnt >= 2'h2 && !r.addr[0]) begin
							n.arr_go = 1'b1;
							n.arr_cmd = r.opc;
							n.busy_arr = 1'b1;
						end
					end
				end
				ST_DUMMY, ST_OUT: begin
					if (r.opc == OPC_RELEASE) begin
						n.pdn = 1'b0;
					end
				end
				default: n.pdn = r.pdn;
			endcase
		end else if (rise) begin
			n.sh = byte_in;
			n.bcnt = r.bcnt + 3'h1;
			if (r.bcnt == 3'h7) begin
				case (r.state)
					ST_CMD: begin
						n.opc = byte_in;
						n.nb = 2'h0;
						n.dcnt = 2'h0;
						n.ocnt = 3'h0;
						if (r.pdn) begin
							n.state = (byte_in == OPC_RELEASE) ? ST_DUMMY : ST_IGN;
						end else if (busy && byte_in != OPC_RDSR) begin
							n.state = ST_IGN;
						end else begin
							case (byte_in)
								OPC_RDSR: begin
									n.state = ST_OUT;
									n.src = SRC_STAT;
								end
								OPC_WREN, OPC_WRDI, OPC_CERASE, OPC_PDOWN: n.state = ST_END;
								OPC_WRSR: n.state = ST_WDATA;
								OPC_READ, OPC_PROG, OPC_SERASE: n.state = ST_ADDR;
								OPC_RELEASE: n.state = ST_DUMMY;
								default: n.state = ST_IGN;
							endcase
						end
					end
					ST_ADDR: begin
						n.addr = {r.addr[15:0], byte_in};
						n.nb = r.nb + 2'h1;
						if (r.nb == ADDR_LAST_IDX) begin
							case (r.opc)
								OPC_READ: begin
									n.state = ST_OUT;
									n.src = SRC_ARR;
									n.mem_rd = 1'b1;
								end
								OPC_PROG: n.state = ST_WDATA;
								default: n.state = ST_END;
							endcase
						end
					end
					ST_DUMMY: begin
						n.nb = r.nb + 2'h1;
						if (r.nb == ADDR_LAST_IDX) begin
							n.state = ST_OUT;
							n.src = SRC_ID;
						end
					end
					ST_WDATA: begin
						if (r.dcnt != 2'h3) begin
							n.dcnt = r.dcnt + 2'h1;
						end
						if (r.opc == OPC_WRSR) begin
							n.wdata = byte_in;
							if (r.dcnt != 2'h0) begin
								n.state = ST_IGN;
							end
						end else if (r.write_latch_flag) begin
							n.prog_we = 1'b1;
							n.prog_data = byte_in;
						end
					end
					ST_END: n.state = ST_IGN;
					default: n.state = r.state;
				endcase
			end
		end else if (fall && r.state == ST_OUT) begin
			n.so_oe = 1'b1;
			n.ocnt = r.ocnt + 3'h1;
			if (r.ocnt == 3'h0) begin
				case (r.src)
					SRC_STAT: ob = stat;
					SRC_ARR: ob = r.rbuf;
					default: ob = SFCD_ID_BYTE;
				endcase
				n.so = ob[7];
				n.osh = {ob[6:0], 1'b0};
				n.mem_rd = (r.src == SRC_ARR);
			end else begin
				n.so = r.osh[7];
				n.osh = {r.osh[6:0], 1'b0};
			end
		end
		if (cs_s) begin
			n.state = ST_CMD;
			n.bcnt = 3'h0;
			n.ocnt = 3'h0;
			n.so_oe = 1'b0;
		end
	end
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			r <= '0;
			r.state <= ST_CMD;
			r.src <= SRC_STAT;
			r.cs_d <= 1'b1;
			// matches the synchronised idle-low clock, so no false edge after reset
			r.sck_d <= 1'b0;
			r.write_latch_flag <= STAT_WEL_RST;
			r.lock <= STAT_LOCK_RST;
			r.bp <= STAT_BP_RST;
		end else begin
			r <= n;
		end
	end

	assign SO = r.so;
	assign SO_OE = r.so_oe;
	assign MEM_ADDR = r.addr;
	assign MEM_RD = r.mem_rd;
	assign ARRAY_GO = r.arr_go;
	assign ARRAY_CMD = r.arr_cmd;
	assign PROG_WE = r.prog_we;
	assign PROG_DATA = r.prog_data;

	// ============================================================
	// assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	property p_wren;
		cs_up && r.state == ST_END && r.opc == OPC_WREN && r.bcnt == 3'h0 |=> r.write_latch_flag;
	endproperty
	a_wren: assert property (p_wren) else $error("write enable did not set latch");
	property p_wrdi;
		cs_up && r.state == ST_END && r.opc == OPC_WRDI && r.bcnt == 3'h0 |=> !r.write_latch_flag;
	endproperty
	a_wrdi: assert property (p_wrdi) else $error("write disable did not clear latch");
	property p_go_needs_wel;
		$rose(r.busy_ws) || r.arr_go |-> $past(r.write_latch_flag);
	endproperty
	a_go_needs_wel: assert property (p_go_needs_wel) else $error("write ran without latch");
	property p_ws_end;
		$fell(r.busy_ws) |-> !r.write_latch_flag && r.lock == r.wdata[7] && r.bp == r.wdata[4:2];
	endproperty
	a_ws_end: assert property (p_ws_end) else $error("status write end wrong");
	property p_stat_first;
		fall && r.state == ST_OUT && r.src == SRC_STAT && r.ocnt == 3'h0 |=> r.so == $past(stat[7]);
	endproperty
	a_stat_first: assert property (p_stat_first) else $error("status msb not driven");
	property p_reserved;
		stat[6:5] == 2'b00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved status bits set");
	property p_guard;
		$rose(r.busy_ws) |-> !$past(r.lock) || $past(wp_s);
	endproperty
	a_guard: assert property (p_guard) else $error("locked status write accepted");
	property p_boundary;
		$rose(r.busy_ws) |-> $past(r.bcnt) == 3'h0 && $past(r.dcnt) == 2'h1;
	endproperty
	a_boundary: assert property (p_boundary) else $error("status write off boundary");
	property p_rd_idle;
		r.mem_rd |-> !busy;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("array read while busy");
	property p_incr;
		r.rd_wait |=> r.addr == $past(r.addr) + 24'h000001;
	endproperty
	a_incr: assert property (p_incr) else $error("address not incremented");
	property p_oe_off;
		cs_s |=> !r.so_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
	property p_ws_len;
		$rose(r.busy_ws) |-> r.busy_ws [*2];
	endproperty
	a_ws_len: assert property (p_ws_len) else $error("status write cycle too short");
	c_rdsr: cover property (fall && r.state == ST_OUT && r.src == SRC_STAT);
	c_read: cover property (r.rd_wait && r.state == ST_OUT);
	c_wrsr: cover property ($rose(r.busy_ws));
	c_id: cover property (fall && r.state == ST_OUT && r.src == SRC_ID);
endmodule : sfcd_decoder

// ---- sfcd_host.sv ----
// ==========================================
// spi host: mode 0, sck idle low, 8 clk per phase pair
module sfcd_host (
	input wire logic clk,
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	task automatic sel();
		@(negedge clk);
		cs_n = 1'b0;
		repeat (4) @(negedge clk);
	endtask : sel
	// shift n bits of tx, sample so just before each rising sck
	task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			si = tx[i];
			repeat (4) @(negedge clk);
			rx[i] = so;
			sck = 1'b1;
			repeat (4) @(negedge clk);
			sck = 1'b0;
		end
	endtask : bits
	// released data line shows the inverse of its last value
	task automatic desel();
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		si = ~si;
		repeat (8) @(negedge clk);
	endtask : desel
endmodule : sfcd_host

// ---- testbench.sv ----
module testbench;
	import sfcd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic WP_N = 1'b1;
	logic ARRAY_DONE = 1'b0;
	logic CS_N, SCK, SI, SO, SO_OE, MEM_RD, ARRAY_GO, PROG_WE;
	logic [23:0] MEM_ADDR, a, a_d;
	logic [7:0] MEM_RDATA = 8'h00;
	logic [7:0] ARRAY_CMD, PROG_DATA, r, s, d, st;
	logic [31:0] lfsr = 32'h6E53;
	logic rd_d = 1'b0;
	logic so_last = 1'b0;
	logic [7:0] pd = 8'h00;
	int fail_count = 0, checks_done = 0, nrd = 0, noe = 0, ngo = 0, acnt = 0, nwe = 0;
	always #10 CLK = ~CLK;
	sfcd_decoder #(.STATUS_WRITE_TIME_NS(20000)) dut_u (.CLK(CLK), .RESETN(RESETN),
		.CS_N(CS_N), .SCK(SCK), .SI(SI), .WP_N(WP_N), .SO(SO), .SO_OE(SO_OE),
		.MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA), .ARRAY_GO(ARRAY_GO),
		.ARRAY_CMD(ARRAY_CMD), .ARRAY_DONE(ARRAY_DONE), .PROG_WE(PROG_WE),
		.PROG_DATA(PROG_DATA));
	// released output line shows the inverse of the last driven bit
	wire so_line = SO_OE ? SO : ~so_last;
	sfcd_host host_u (.clk(CLK), .cs_n(CS_N), .sck(SCK), .si(SI), .so(so_line));
	function automatic logic [7:0] mem_f(logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h3C;
	endfunction : mem_f
	function automatic logic [31:0] nxt(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt
	// ==========================================
	// array memory and engine models
	always @(negedge CLK) begin
		if (rd_d) begin
			MEM_RDATA <= mem_f(a_d);
		end else begin
			MEM_RDATA <= ~MEM_RDATA;
		end
		rd_d <= MEM_RD;
		a_d <= MEM_ADDR;
		nrd += int'(MEM_RD);
		noe += int'(SO_OE);
		ngo += int'(ARRAY_GO);
		nwe += int'(PROG_WE);
		if (PROG_WE) begin
			pd = PROG_DATA;
		end
		if (SO_OE) begin
			so_last = SO;
		end
		if (ARRAY_GO) begin
			acnt = 300;
		end else if (acnt > 0) begin
			acnt--;
		end
		ARRAY_DONE <= (acnt == 1);
	end
	// ==========================================
	// helpers
	task automatic chk(string nm, logic [7:0] sn, logic [7:0] ex);
		checks_done++;
		if (sn !== ex) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, ex, sn);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop
	task automatic op1(logic [7:0] o);
		host_u.sel();
		host_u.bits(o, 8, r);
		host_u.desel();
	endtask : op1
	task automatic rdsr();
		host_u.sel();
		host_u.bits(OPC_RDSR, 8, r);
		host_u.bits(8'h00, 8, s);
		host_u.bits(8'h00, 8, r);
		chk("stat_repeat", r, (s[0] && !r[0]) ? (s & 8'hFC) : s);
		host_u.desel();
	endtask : rdsr
	task automatic wrsr(logic [7:0] v, int n);
		host_u.sel();
		host_u.bits(OPC_WRSR, 8, r);
		host_u.bits(v, n, r);
		host_u.desel();
	endtask : wrsr
	task automatic wait_idle();
		repeat (20) begin
			rdsr();
			if (s[0] !== 1'b1) break;
		end
	endtask : wait_idle
	initial begin
		#1000000;
		fail_count++;
		report_and_stop();
	end
	// ==========================================
	// main sequence
	initial begin
		repeat (10) @(negedge CLK);
		RESETN = 1'b1;
		repeat (5) @(negedge CLK);
		rdsr();
		chk("stat_rst", s, 8'h00);
		op1(OPC_WREN);
		rdsr();
		chk("wel_set", s, 8'h02);
		op1(OPC_WRDI);
		rdsr();
		chk("wel_clr", s, 8'h00);
		wrsr(8'hFC, 8);
		rdsr();
		chk("wrsr_nowel", s, 8'h00);
		op1(OPC_WREN);
		wrsr(8'hFC, 7);
		rdsr();
		chk("wrsr_part", s, 8'h02);
		wrsr(8'h88, 8);
		wait_idle();
		chk("lock_set", s, 8'h88);
		WP_N = 1'b0;
		op1(OPC_WREN);
		wrsr(8'h04, 8);
		wait_idle();
		chk("locked", s, 8'h8A);
		WP_N = 1'b1;
		wrsr(8'h04, 8);
		wait_idle();
		chk("unlocked", s, 8'h04);
		st = 8'h04;
		repeat (4) begin
			lfsr = nxt(lfsr);
			d = lfsr[7:0];
			op1(OPC_WREN);
			wrsr(d, 8);
			rdsr();
			chk("busy", s, st | 8'h03);
			noe = 0;
			nrd = 0;
			host_u.sel();
			for (int k = 0; k < 5; k++) host_u.bits(k == 0 ? OPC_READ : d, 8, r);
			host_u.desel();
			chk("rd_busy", {7'h00, noe != 0 || nrd != 0}, 8'h00);
			wait_idle();
			st = {d[7], 2'b00, d[4:2], 2'b00};
			chk("wrsr", s, st);
		end
		repeat (3) begin
			lfsr = nxt(lfsr);
			a = lfsr[23:0];
			host_u.sel();
			host_u.bits(OPC_READ, 8, r);
			for (int k = 2; k >= 0; k--) host_u.bits(a[8*k+:8], 8, r);
			for (int k = 0; k < 3; k++) begin
				host_u.bits(8'h00, 8, r);
				chk("rd", r, mem_f(a + 24'(k)));
			end
			host_u.desel();
		end
		op1(OPC_PDOWN);
		noe = 0;
		rdsr();
		chk("pdn_ign", 8'(noe), 8'h00);
		host_u.sel();
		for (int k = 0; k < 4; k++) host_u.bits(k == 0 ? OPC_RELEASE : 8'h00, 8, r);
		repeat (2) begin
			host_u.bits(8'h00, 8, r);
			chk("id", r, SFCD_ID_BYTE);
		end
		host_u.desel();
		rdsr();
		chk("pdn_rel", s, st);
		ngo = 0;
		op1(OPC_CERASE);
		chk("go_nowel", 8'(ngo), 8'h00);
		op1(OPC_WREN);
		op1(OPC_CERASE);
		chk("go", 8'(ngo), 8'h01);
		chk("cmd", ARRAY_CMD, OPC_CERASE);
		rdsr();
		chk("erase_busy", s, st | 8'h03);
		wait_idle();
		chk("erase_done", s, st);
		// page program: even start address runs, odd one is refused
		for (int j = 0; j < 2; j++) begin
			lfsr = nxt(lfsr);
			a = {lfsr[23:1], j[0]};
			ngo = 0;
			nwe = 0;
			op1(OPC_WREN);
			host_u.sel();
			host_u.bits(OPC_PROG, 8, r);
			for (int k = 2; k >= 0; k--) host_u.bits(a[8*k+:8], 8, r);
			host_u.bits(lfsr[31:24], 8, r);
			host_u.bits(d, 8, r);
			host_u.desel();
			chk("prog_we", 8'(nwe), 8'h02);
			chk("prog_data", pd, d);
			chk("prog_addr", MEM_ADDR[7:0], a[7:0]);
			chk("prog_go", 8'(ngo), {7'h00, !j[0]});
			chk("prog_cmd", ARRAY_CMD, OPC_PROG);
			wait_idle();
			chk("prog_done", s, j[0] ? (st | 8'h02) : st);
		end
		ngo = 0;
		op1(OPC_WREN);
		host_u.sel();
		host_u.bits(OPC_SERASE, 8, r);
		for (int k = 2; k >= 0; k--) host_u.bits(a[8*k+:8], 8, r);
		host_u.desel();
		chk("se_go", 8'(ngo), 8'h01);
		chk("se_cmd", ARRAY_CMD, OPC_SERASE);
		wait_idle();
		chk("se_done", s, st);
		report_and_stop();
	end
endmodule : testbench
